// file: banked_mem_params.svh
`ifndef BANKED_MEM_PARAMS_SVH
`define BANKED_MEM_PARAMS_SVH

// apb register offsets
`define OFS_CTRL 12'h000
`define OFS_PAGE 12'h004
`define OFS_STAT 12'h008

// control register layout
`define CTRL_W 17
`define CTRL_SHAPE_LSB 0
`define CTRL_WSRC_LSB 3
`define CTRL_RSRC_LSB 6
`define CTRL_REG_LSB 9
`define CTRL_WE_LOCAL_BIT 15
`define CTRL_RS_LOCAL_BIT 16
`define CTRL_RESET 17'h07E04

// register-enable bits inside the six-bit path field
`define PATH_WDATA 0
`define PATH_RDATA 1
`define PATH_RADDR 2
`define PATH_WADDR 3
`define PATH_WE 4
`define PATH_RS 5

// status register layout
`define STAT_OK_BIT 0
`define STAT_DRIVE_LSB 8
`define STAT_Q_LSB 16

// bank geometry
`define BANK_BITS 2048
`define BANK_AW 11
`define MIN_WORD_AW 7
`define MAX_SHAPE 3'h4
`define DATA_W 16
`define DED_CLKS 4

`endif

// file: banked_mem_pkg.sv
package banked_mem_pkg;

    // source of a side clock
    typedef enum logic [2:0] {
        SRC_GLOBAL = 3'h0,
        SRC_DED0 = 3'h1,
        SRC_DED1 = 3'h2,
        SRC_DED2 = 3'h3,
        SRC_DED3 = 3'h4,
        SRC_LOCAL = 3'h5
    } clk_src_t;

    // bank shape: words x bits
    typedef enum logic [2:0] {
        SHAPE_128X16 = 3'h0,
        SHAPE_256X8 = 3'h1,
        SHAPE_512X4 = 3'h2,
        SHAPE_1024X2 = 3'h3,
        SHAPE_2048X1 = 3'h4
    } shape_t;

endpackage : banked_mem_pkg

// file: banked_deep_memory_ports.sv
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "banked_mem_params.svh"

// Contract
// - deeper than one 2,048-word bank: banks share a column-wide output line
// - each bank decoder drives only when its page code matches upper address
// - 8,192 words use four banks: 11 low bits array, 2 high bits decoder
// - only the bank of the selected 2,048-word page drives the line
// - never two drivers at once, never an undriven shared line
// - separate input-side and output-side clocks
// - six paths each selectably registered or passed through
// - clocks from global, dedicated or locally generated sources
// - clock enable and asynchronous clear inputs for the registers
// - four dedicated clock inputs usable as memory clocks
// - bank shapes 128x16, 256x8, 512x4, 1,024x2, 2,048x1
// - writes synchronous and self-timed from the input clock
// - read and write in the same period on different clocks
module banked_deep_memory_ports #(
    parameter int NBANK = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clk_global,
    input wire logic [`DED_CLKS-1:0] clk_dedicated,
    input wire logic clk_local,
    input wire logic mem_clken,
    input wire logic mem_aclr,
    input wire logic [`DATA_W-1:0] mem_wdata,
    input wire logic [`BANK_AW+$clog2(NBANK)-1:0] mem_waddr,
    input wire logic [`BANK_AW+$clog2(NBANK)-1:0] mem_raddr,
    input wire logic write_strobe_global,
    input wire logic write_strobe_local,
    input wire logic read_strobe_global,
    input wire logic read_strobe_local,
    output logic [`DATA_W-1:0] mem_q,
    output logic [NBANK-1:0] bank_drive
);
    import banked_mem_pkg::*;

    localparam int PW = $clog2(NBANK);
    localparam int AW = `BANK_AW + PW;

    // page codes and drive bits must each fit one 32-bit read word
    if (NBANK < 2 || NBANK > 8 || (NBANK & (NBANK - 1)) != 0) begin : g_chk
        $error("NBANK must be a power of two from 2 to 8");
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave and configuration
    logic [`CTRL_W-1:0] ctrl_ff, nxt_ctrl;
    logic [PW-1:0] page_ff [NBANK];
    logic [PW-1:0] nxt_page [NBANK];
    logic pready_ff, nxt_pready;
    logic pslverr_ff, nxt_pslverr;
    logic [31:0] prdata_ff, nxt_prdata;
    logic codes_ok;
    logic [`DATA_W-1:0] q_ff, nxt_q;
    logic [NBANK-1:0] drive_ff, nxt_drive;
    logic hit;

    shape_t shape;
    logic [5:0] regsel;
    assign shape = shape_t'(ctrl_ff[`CTRL_SHAPE_LSB +: 3]);
    assign regsel = ctrl_ff[`CTRL_REG_LSB +: 6];
    assign hit = paddr == `OFS_CTRL || paddr == `OFS_PAGE
        || paddr == `OFS_STAT;

    // duplicate page codes would let two banks fight the line
    always_comb begin
        codes_ok = 1'b1;
        for (int a = 0; a < NBANK; a++) begin
            for (int b = a + 1; b < NBANK; b++) begin
                if (page_ff[a] == page_ff[b]) begin
                    codes_ok = 1'b0;
                end
            end
        end
    end

    // one wait state; a write lands on the edge that completes the access
    always_comb begin
        nxt_ctrl = ctrl_ff;
        nxt_page = page_ff;
        nxt_pready = psel && penable && !pready_ff;
        nxt_pslverr = 1'b0;
        nxt_prdata = prdata_ff;
        if (psel && penable && !pready_ff) begin
            nxt_pslverr = !hit;
            nxt_prdata = 32'h0000_0000;
            case (paddr)
                `OFS_CTRL: nxt_prdata[`CTRL_W-1:0] = ctrl_ff;
                `OFS_PAGE: begin
                    for (int b = 0; b < NBANK; b++) begin
                        nxt_prdata[b*PW +: PW] = page_ff[b];
                    end
                end
                `OFS_STAT: begin
                    nxt_prdata[`STAT_OK_BIT] = codes_ok;
                    nxt_prdata[`STAT_DRIVE_LSB +: NBANK] = drive_ff;
                    nxt_prdata[`STAT_Q_LSB +: `DATA_W] = q_ff;
                end
                default: nxt_prdata = 32'h0000_0000;
            endcase
        end
        if (psel && penable && pready_ff && pwrite) begin
            case (paddr)
                `OFS_CTRL: begin
                    nxt_ctrl = pwdata[`CTRL_W-1:0];
                    // unknown shape codes keep the old shape
                    if (pwdata[`CTRL_SHAPE_LSB +: 3] > `MAX_SHAPE) begin
                        nxt_ctrl[`CTRL_SHAPE_LSB +: 3] =
                            ctrl_ff[`CTRL_SHAPE_LSB +: 3];
                    end
                end
                `OFS_PAGE: begin
                    for (int b = 0; b < NBANK; b++) begin
                        nxt_page[b] = pwdata[b*PW +: PW];
                    end
                end
                default: nxt_ctrl = ctrl_ff;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= `CTRL_RESET;
            for (int b = 0; b < NBANK; b++) begin
                page_ff[b] <= PW'(b);
            end
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            page_ff <= nxt_page;
            pready_ff <= nxt_pready;
            pslverr_ff <= nxt_pslverr;
            prdata_ff <= nxt_prdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // side clock selection and strobe sources
    logic [5:0] src_now, src_prev_ff;
    logic wtick, rtick;
    logic we_in, rs_in;

    assign src_now = {clk_local, clk_dedicated, clk_global};

    // sources are sampled levels; a rising edge of the chosen one is a tick
    function automatic logic tick_of(input logic [5:0] now,
                                     input logic [5:0] prev,
                                     input logic [2:0] sel);
        logic t;
        t = 1'b0;
        if (sel <= SRC_LOCAL) begin
            t = now[sel] && !prev[sel];
        end
        return t;
    endfunction : tick_of

    assign wtick = tick_of(src_now, src_prev_ff,
        ctrl_ff[`CTRL_WSRC_LSB +: 3]);
    assign rtick = tick_of(src_now, src_prev_ff,
        ctrl_ff[`CTRL_RSRC_LSB +: 3]);
    assign we_in = ctrl_ff[`CTRL_WE_LOCAL_BIT] ? write_strobe_local
        : write_strobe_global;
    assign rs_in = ctrl_ff[`CTRL_RS_LOCAL_BIT] ? read_strobe_local
        : read_strobe_global;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_prev_ff <= 6'h00;
        end else begin
            src_prev_ff <= src_now;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // optional path registers, cleared asynchronously
    logic [`DATA_W-1:0] wdata_ff, nxt_wdata;
    logic [AW-1:0] waddr_ff, nxt_waddr, raddr_ff, nxt_raddr;
    logic we_ff, nxt_we, rs_ff, nxt_rs;
    logic [`DATA_W-1:0] wd_eff, rd_bus;
    logic [AW-1:0] wa_eff, ra_eff;
    logic we_eff, rs_eff, wr_en;

    always_comb begin
        nxt_wdata = wdata_ff;
        nxt_waddr = waddr_ff;
        nxt_we = we_ff;
        nxt_raddr = raddr_ff;
        nxt_rs = rs_ff;
        if (wtick && mem_clken) begin
            nxt_wdata = mem_wdata;
            nxt_waddr = mem_waddr;
            nxt_we = we_in;
        end
        if (rtick && mem_clken) begin
            nxt_raddr = mem_raddr;
            nxt_rs = rs_in;
        end
    end

    // each path either uses its register or the live input
    assign wd_eff = regsel[`PATH_WDATA] ? wdata_ff : mem_wdata;
    assign wa_eff = regsel[`PATH_WADDR] ? waddr_ff : mem_waddr;
    assign we_eff = regsel[`PATH_WE] ? we_ff : we_in;
    assign ra_eff = regsel[`PATH_RADDR] ? raddr_ff : mem_raddr;
    assign rs_eff = regsel[`PATH_RS] ? rs_ff : rs_in;
    // write pulse made inside from the input-side tick
    assign wr_en = wtick && mem_clken && we_eff;

    always_comb begin
        nxt_q = q_ff;
        if (regsel[`PATH_RDATA]) begin
            if (rtick && mem_clken && rs_eff) begin
                nxt_q = rd_bus;
            end
        end else if (rs_eff) begin
            nxt_q = rd_bus;
        end
    end

    always_ff @(posedge pclk or negedge presetn or posedge mem_aclr) begin
        if (!presetn || mem_aclr) begin
            wdata_ff <= 16'h0000;
            waddr_ff <= '0;
            we_ff <= 1'b0;
            raddr_ff <= '0;
            rs_ff <= 1'b0;
            q_ff <= 16'h0000;
        end else begin
            wdata_ff <= nxt_wdata;
            waddr_ff <= nxt_waddr;
            we_ff <= nxt_we;
            raddr_ff <= nxt_raddr;
            rs_ff <= nxt_rs;
            q_ff <= nxt_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // banks, page decoders and the shared output line
    function automatic logic [PW-1:0] page_of(input logic [AW-1:0] a,
                                              input shape_t s);
        logic [AW-1:0] sh;
        sh = a >> (`MIN_WORD_AW + int'(s));
        return sh[PW-1:0];
    endfunction : page_of

    // word address scaled by word width gives the first bit in the bank
    function automatic logic [`BANK_AW-1:0] base_of(input logic [AW-1:0] a,
                                                    input shape_t s);
        logic [`BANK_AW-1:0] lo;
        lo = a[`BANK_AW-1:0] & `BANK_AW'((1 << (`MIN_WORD_AW + int'(s))) - 1);
        return `BANK_AW'(lo << (int'(`MAX_SHAPE) - int'(s)));
    endfunction : base_of

    logic [`BANK_BITS-1:0] mem_ff [NBANK];
    logic [`BANK_BITS-1:0] nxt_mem [NBANK];
    logic [NBANK-1:0] wsel, rsel;
    logic [PW-1:0] wpage, rpage;
    logic [`BANK_AW-1:0] wbase, rbase;
    int width;

    assign wpage = page_of(wa_eff, shape);
    assign rpage = page_of(ra_eff, shape);
    assign wbase = base_of(wa_eff, shape);
    assign rbase = base_of(ra_eff, shape);
    assign width = `DATA_W >> int'(shape);

    // bad code sets fall back to bank order, so the codes always form a
    // permutation and exactly one bank matches any page
    always_comb begin
        for (int b = 0; b < NBANK; b++) begin
            wsel[b] = (codes_ok ? page_ff[b] : PW'(b)) == wpage;
            rsel[b] = (codes_ok ? page_ff[b] : PW'(b)) == rpage;
        end
    end

    // and-or of gated drivers stands for the column tri-state line
    always_comb begin
        rd_bus = 16'h0000;
        for (int b = 0; b < NBANK; b++) begin
            for (int j = 0; j < `DATA_W; j++) begin
                if (rsel[b] && j < width) begin
                    rd_bus[j] = rd_bus[j]
                        | mem_ff[b][rbase + `BANK_AW'(j)];
                end
            end
        end
    end

    assign nxt_drive = rsel;

    for (genvar g = 0; g < NBANK; g++) begin : g_bank
        always_comb begin
            nxt_mem[g] = mem_ff[g];
            if (wr_en && wsel[g]) begin
                for (int j = 0; j < `DATA_W; j++) begin
                    if (j < width) begin
                        nxt_mem[g][wbase + `BANK_AW'(j)] = wd_eff[j];
                    end
                end
            end
        end

        // array contents are not reset, as in a real ram
        always_ff @(posedge pclk) begin
            mem_ff[g] <= nxt_mem[g];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            drive_ff <= '0;
        end else begin
            drive_ff <= nxt_drive;
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign mem_q = q_ff;
    assign bank_drive = drive_ff;

endmodule : banked_deep_memory_ports

// file: bdm_chk.sv
`timescale 1ns/1ps
`include "banked_mem_params.svh"
module bdm_chk #(
    parameter int NBANK = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_aclr,
    input wire logic [`DATA_W-1:0] mem_q,
    input wire logic [NBANK-1:0] bank_drive
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    a_one_wait: assert property (psel && !penable ##1 psel && penable
        |-> !pready ##1 pready) else $error("apb wait state wrong");
    a_err_map: assert property (psel && pready && paddr[1:0] == 2'h0
        |-> pslverr == (paddr > 12'h008)) else $error("pslverr wrong");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_err_rdata: assert property (pslverr |-> prdata == 32'h0)
        else $error("error read not zero");
    a_rdata_hold: assert property ($changed(prdata) |-> pready)
        else $error("prdata moved outside answer");
    a_drive_onehot: assert property ($past(presetn)
        |-> $onehot(bank_drive)) else $error("bank drivers not one-hot");
    a_aclr_zero: assert property (mem_aclr |-> mem_q == '0)
        else $error("mem_q not cleared");
    a_aclr_hold: assert property ($fell(mem_aclr) |-> mem_q == '0)
        else $error("mem_q left zero early");
    c_unmapped: cover property (pslverr);
    c_clear: cover property (mem_aclr);
    c_top_bank: cover property (bank_drive[NBANK-1]);
endmodule : bdm_chk

// file: bdm_user_logic.sv
`timescale 1ns/1ps
`include "banked_mem_params.svh"
module bdm_user_logic (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    output logic clk_global,
    output logic [`DED_CLKS-1:0] clk_dedicated,
    output logic clk_local
);
    logic [5:0] cnt_ff;
    logic [5:0] nxt_cnt;
    logic [4:0] div;
    always_comb begin
        nxt_cnt = cnt_ff + 6'h01;
        div = slow ? cnt_ff[5:1] : cnt_ff[4:0];
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_ff <= 6'h00;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
    // power-of-two rates of one counter: global equals dedicated 0, local equals dedicated 1
    assign clk_global = div[1];
    assign clk_dedicated = div[`DED_CLKS:1];
    assign clk_local = div[2];
endmodule : bdm_user_logic

// file: banked_deep_memory_ports_test.sv
`timescale 1ns/1ps
`include "banked_mem_params.svh"
module banked_deep_memory_ports_test;
    localparam int NBANK = 4;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic clk_global, clk_local, mem_clken, mem_aclr, slow;
    logic [3:0] clk_dedicated, bank_drive;
    logic [15:0] mem_wdata, mem_q, wv;
    logic [12:0] mem_waddr, mem_raddr, a;
    logic ws_g, ws_l, rs_g, rs_l, loc, d;
    logic pm [0:8191];
    logic [1:0] code [0:3];
    int err_count, n_compared, seed, h, src;
    banked_deep_memory_ports #(.NBANK(NBANK)) dut_u (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
        .prdata, .pready, .pslverr, .clk_global, .clk_dedicated,
        .clk_local, .mem_clken, .mem_aclr, .mem_wdata, .mem_waddr,
        .mem_raddr, .write_strobe_global(ws_g), .write_strobe_local(ws_l),
        .read_strobe_global(rs_g), .read_strobe_local(rs_l), .mem_q,
        .bank_drive);
    bdm_user_logic ul_u (.pclk, .presetn, .slow, .clk_global,
        .clk_dedicated, .clk_local);
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task test_done;
        if (err_count == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : test_done
    task chk_reg(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t reg got %h exp %h", $time, g, e);
        end
    endtask : chk_reg
    task chk_mem(input logic [15:0] g, input logic [15:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %0t port got %h exp %h", $time, g, e);
        end
    endtask : chk_mem
    task apb(input logic [11:0] ad, input logic w, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= ad;
        pwrite <= w;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) err_count++;
    endtask : apb
    function int bank_of(input logic [1:0] pg);
        int b;
        b = 0;
        for (int i = 0; i < 4; i++) if (code[i] == pg) b = i;
        return b;
    endfunction : bank_of
    task mwr(input logic [12:0] ad, input logic dv);
        @(posedge pclk);
        mem_waddr <= ad;
        mem_wdata <= {15'h0, dv};
        ws_g <= !loc;
        ws_l <= loc;
        repeat (h) @(posedge pclk);
        ws_g <= 1'b0;
        ws_l <= 1'b0;
        pm[bank_of(ad[12:11]) * 2048 + ad[10:0]] = dv;
    endtask : mwr
    task mrd(input logic [12:0] ad, input logic z);
        @(posedge pclk);
        mem_raddr <= ad;
        rs_g <= !loc;
        rs_l <= loc;
        repeat (h) @(posedge pclk);
        rs_g <= 1'b0;
        rs_l <= 1'b0;
        chk_mem(mem_q, z ? 16'h0 : {15'h0, pm[bank_of(ad[12:11]) * 2048
            + ad[10:0]]});
        if (!z) chk_mem({12'h0, bank_drive},
            16'h1 << bank_of(ad[12:11]));
    endtask : mrd
    ////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 43;
        err_count = 0;
        n_compared = 0;
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {slow, mem_aclr, mem_wdata, mem_waddr, mem_raddr} = '0;
        {ws_g, ws_l, rs_g, rs_l, loc} = '0;
        mem_clken = 1'b1;
        h = 40;
        for (int i = 0; i < 4; i++) code[i] = 2'(i);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(`OFS_CTRL, 1'b0, 32'h0);
        chk_reg(rd, 32'h07E04);
        apb(`OFS_PAGE, 1'b0, 32'h0);
        chk_reg(rd, 32'hE4);
        apb(`OFS_STAT, 1'b0, 32'h0);
        chk_reg({31'h0, rd[0]}, 32'h1);
        apb(12'h00C, 1'b0, 32'h0);
        chk_reg({er, rd[30:0]}, 32'h80000000);
        // shape 5 is illegal and must leave shape 4 in place
        for (int s = 0; s < 6; s++) begin
            apb(`OFS_CTRL, 1'b1, 32'(s));
            apb(`OFS_CTRL, 1'b0, 32'h0);
            chk_reg(rd, (s > 4) ? 32'h4 : 32'(s));
        end
        for (int m = 0; m < 2; m++) begin
            slow <= (m == 1);
            h = m ? 260 : 40;
            if (m == 1) begin
                apb(`OFS_PAGE, 1'b1, 32'h1B);
                for (int i = 0; i < 4; i++) code[i] = 2'(3 - i);
            end
            for (src = 0; src < 6; src++) begin
                loc = src[0];
                apb(`OFS_CTRL, 1'b1, {loc, loc, m ? 6'h3F : 6'h00,
                    src[2:0], 3'(5 - src), 3'h4});
                a = (src == 0) ? 13'h07FF : 13'($random(seed));
                d = 1'($random(seed));
                mwr(a, 1'b1);
                mwr(a ^ 13'h1800, d);
                mrd(a ^ 13'h1800, 1'b0);
                mrd(a, 1'b0);
                mem_aclr <= 1'b1;
                @(posedge pclk);
                @(posedge pclk);
                chk_mem(mem_q, 16'h0);
                mem_aclr <= 1'b0;
                mem_clken <= (m == 0);
                if (m == 1) mrd(a, 1'b1);
                mem_clken <= 1'b1;
                mrd(a, 1'b0);
            end
        end
        // duplicate codes: decoders fall back to bank order
        apb(`OFS_PAGE, 1'b1, 32'h0);
        for (int i = 0; i < 4; i++) code[i] = 2'(i);
        apb(`OFS_STAT, 1'b0, 32'h0);
        chk_reg({31'h0, rd[0]}, 32'h0);
        // widest shape 128x16: page sits in address bits 8:7
        apb(`OFS_CTRL, 1'b1, 32'h0);
        wv = 16'($random(seed));
        @(posedge pclk);
        mem_waddr <= 13'h0155;
        mem_raddr <= 13'h0155;
        mem_wdata <= wv;
        ws_g <= 1'b1;
        repeat (h) @(posedge pclk);
        ws_g <= 1'b0;
        rs_g <= 1'b1;
        repeat (h) @(posedge pclk);
        rs_g <= 1'b0;
        chk_mem(mem_q, wv);
        chk_mem({12'h0, bank_drive}, 16'h4);
        test_done;
    end
    initial begin
        #(40 * 30000);
        err_count++;
        test_done;
    end
endmodule : banked_deep_memory_ports_test
bind banked_deep_memory_ports bdm_chk #(.NBANK(NBANK)) chk_u (.*);
